//--- hw/spvcr_regs.svh
// Offsets, field positions, reset values of the port configuration registers
`ifndef SPVCR_REGS_SVH
`define SPVCR_REGS_SVH
`define SPVCR_OFS_MSG_DATA    8'h58
`define SPVCR_OFS_CAP_HDR     8'h64
`define SPVCR_OFS_SCRATCH0    8'h68
`define SPVCR_OFS_SCRATCH1    8'h6C
`define SPVCR_OFS_TIMER_CTL   8'h70
`define SPVCR_OFS_FWD_MODE    8'h74
`define SPVCR_CAP_ID          8'h09
`define SPVCR_CAP_NEXT        8'hB0
`define SPVCR_CAP_LEN         16'h0034
`define SPVCR_SCRATCH0_RST    32'h04001060
`define SPVCR_SCRATCH1_RST    32'h00000800
`define SPVCR_MSG_DATA_RST    16'h0000
`define SPVCR_REPLAY_VAL_RST  12'h000
`define SPVCR_ACK_VAL_RST     14'h0000
`define SPVCR_CT_THR_RST      2'h1
`define SPVCR_BIT_REPLAY_EN   12
`define SPVCR_BIT_PM_DIS      13
`define SPVCR_BIT_MSI_DIS     14
`define SPVCR_BIT_ACK_EN      30
`define SPVCR_BIT_VGA_EN      31
`define SPVCR_BIT_STORE_FWD   0
`define SPVCR_BIT_ARB_HOLD    3
`define SPVCR_REPLAY_DEF      12'h0FF
`define SPVCR_ACK_DEF         14'h0040
`endif

//--- hw/spvcr_pkg.sv
// Types shared by the port configuration register bank
package spvcr_pkg;
  typedef enum logic [2:0] {
    SPVCR_SEL_NONE     = 3'h0,
    SPVCR_SEL_MSG_DATA = 3'h1,
    SPVCR_SEL_CAP_HDR  = 3'h2,
    SPVCR_SEL_SCRATCH0 = 3'h3,
    SPVCR_SEL_SCRATCH1 = 3'h4,
    SPVCR_SEL_TIMER    = 3'h5,
    SPVCR_SEL_FWD_MODE = 3'h6
  } spvcr_sel_e;
  typedef logic [31:0] spvcr_word_t;
endpackage

//--- hw/spvcr_regbank.sv
// Vendor configuration register bank of a switch port
//
// Contract
// - Capability ID byte reads fixed 09h
// - Next pointer byte reads fixed B0h
// - Upper header half reads length 0034h
// - User replay timeout 12 bits, reset zero
// - Bit 12 selects user replay timeout
// - User ack latency 14 bits, reset zero
// - Bit 30 selects user ack latency
// - Bit 31 VGA decode reads one
// - SMBus or EEPROM load replaces defaults
// - Mode bit 0 selects store-and-forward
// - Cut-through threshold code, reset 01b
// - Bit 3 set holds arbiter on grant
// - Bit 3 clear moves to credited requester
// - Two test scratch words with resets
`timescale 1ns/100ps
`include "spvcr_regs.svh"

module spvcr_regbank
  import spvcr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Configuration access port
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata_q,
  output logic             cfg_rd_ack_q,
  // Default load port from SMBus or EEPROM
  input  wire logic        load_wr,
  input  wire logic [7:0]  load_addr,
  input  wire logic [31:0] load_data,
  // Controls to the port logic
  output logic      [15:0] msg_data_q,
  output logic      [11:0] replay_timeout_q,
  output logic      [13:0] ack_latency_q,
  output logic             pm_cap_dis_q,
  output logic             msi_cap_dis_q,
  output logic             vga_decode_en_q,
  output logic             store_forward_q,
  output logic      [1:0]  ct_early_cycles_q,
  output logic             arb_hold_grant_q,
  output logic      [31:0] scratch0_q,
  output logic      [31:0] scratch1_q
);

  // Decode a byte offset into a register select
  function automatic spvcr_sel_e reg_sel(input logic [7:0] a);
    case (a)
      `SPVCR_OFS_MSG_DATA:  reg_sel = SPVCR_SEL_MSG_DATA;
      `SPVCR_OFS_CAP_HDR:   reg_sel = SPVCR_SEL_CAP_HDR;
      `SPVCR_OFS_SCRATCH0:  reg_sel = SPVCR_SEL_SCRATCH0;
      `SPVCR_OFS_SCRATCH1:  reg_sel = SPVCR_SEL_SCRATCH1;
      `SPVCR_OFS_TIMER_CTL: reg_sel = SPVCR_SEL_TIMER;
      `SPVCR_OFS_FWD_MODE:  reg_sel = SPVCR_SEL_FWD_MODE;
      default:              reg_sel = SPVCR_SEL_NONE;
    endcase
  endfunction

  // Merge new data into an old word under byte enables
  function automatic spvcr_word_t be_merge(input spvcr_word_t old_w,
                                           input spvcr_word_t new_w,
                                           input logic [3:0]  be);
    spvcr_word_t m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    be_merge = m;
  endfunction

  // Stored register state
  logic [15:0] msg_q,      msg_d;
  logic [31:0] scr0_q,     scr0_d;
  logic [31:0] scr1_q,     scr1_d;
  logic [11:0] rpl_val_q,  rpl_val_d;
  logic        rpl_en_q,   rpl_en_d;
  logic [13:0] ack_val_q,  ack_val_d;
  logic        ack_en_q,   ack_en_d;
  logic        pm_dis_q,   pm_dis_d;
  logic        msi_dis_q,  msi_dis_d;
  logic        sf_q,       sf_d;
  logic [1:0]  ct_q,       ct_d;
  logic        arb_q,      arb_d;
  logic [31:0] rdata_d;
  logic        rd_ack_d;
  logic [11:0] rpl_eff_d;
  logic [13:0] ack_eff_d;
  spvcr_sel_e  wsel;
  spvcr_sel_e  lsel;
  spvcr_sel_e  rsel;
  spvcr_word_t timer_word;
  spvcr_word_t mode_word;
  spvcr_word_t cap_word;
  spvcr_word_t w;

  // Register images as software sees them
  always_comb begin
    timer_word = 32'h00000000;
    timer_word[11:0]  = rpl_val_q;
    timer_word[`SPVCR_BIT_REPLAY_EN] = rpl_en_q;
    timer_word[`SPVCR_BIT_PM_DIS]    = pm_dis_q;
    timer_word[`SPVCR_BIT_MSI_DIS]   = msi_dis_q;
    timer_word[29:16] = ack_val_q;
    timer_word[`SPVCR_BIT_ACK_EN]    = ack_en_q;
    timer_word[`SPVCR_BIT_VGA_EN]    = 1'b1;
    mode_word = 32'h00000000;
    mode_word[`SPVCR_BIT_STORE_FWD] = sf_q;
    mode_word[2:1] = ct_q;
    mode_word[`SPVCR_BIT_ARB_HOLD]  = arb_q;
    cap_word = {`SPVCR_CAP_LEN, `SPVCR_CAP_NEXT, `SPVCR_CAP_ID};
  end

  // Next state of all stored fields
  always_comb begin
    wsel = reg_sel(cfg_addr);
    lsel = reg_sel(load_addr);
    rsel = reg_sel(cfg_addr);
    msg_d     = msg_q;
    scr0_d    = scr0_q;
    scr1_d    = scr1_q;
    rpl_val_d = rpl_val_q;
    rpl_en_d  = rpl_en_q;
    ack_val_d = ack_val_q;
    ack_en_d  = ack_en_q;
    pm_dis_d  = pm_dis_q;
    msi_dis_d = msi_dis_q;
    sf_d      = sf_q;
    ct_d      = ct_q;
    arb_d     = arb_q;
    w         = 32'h00000000;
    // Software writes reach only the RW fields
    if (cfg_wr) begin
      case (wsel)
        SPVCR_SEL_MSG_DATA: begin
          w = be_merge({16'h0000, msg_q}, cfg_wdata, cfg_be);
          msg_d = w[15:0];
        end
        SPVCR_SEL_SCRATCH0: begin
          scr0_d = be_merge(scr0_q, cfg_wdata, cfg_be);
        end
        SPVCR_SEL_SCRATCH1: begin
          scr1_d = be_merge(scr1_q, cfg_wdata, cfg_be);
        end
        SPVCR_SEL_TIMER: begin
          w = be_merge(timer_word, cfg_wdata, cfg_be);
          rpl_val_d = w[11:0];
          rpl_en_d  = w[`SPVCR_BIT_REPLAY_EN];
          ack_val_d = w[29:16];
          ack_en_d  = w[`SPVCR_BIT_ACK_EN];
        end
        SPVCR_SEL_FWD_MODE: begin
          w = be_merge(mode_word, cfg_wdata, cfg_be);
          sf_d  = w[`SPVCR_BIT_STORE_FWD];
          ct_d  = w[2:1];
          arb_d = w[`SPVCR_BIT_ARB_HOLD];
        end
        default: begin
          w = 32'h00000000;
        end
      endcase
    end
    // default load wins over software, includes RO disables
    if (load_wr) begin
      case (lsel)
        SPVCR_SEL_TIMER: begin
          rpl_val_d = load_data[11:0];
          rpl_en_d  = load_data[`SPVCR_BIT_REPLAY_EN];
          pm_dis_d  = load_data[`SPVCR_BIT_PM_DIS];
          msi_dis_d = load_data[`SPVCR_BIT_MSI_DIS];
          ack_val_d = load_data[29:16];
          ack_en_d  = load_data[`SPVCR_BIT_ACK_EN];
        end
        SPVCR_SEL_FWD_MODE: begin
          sf_d  = load_data[`SPVCR_BIT_STORE_FWD];
          ct_d  = load_data[2:1];
          arb_d = load_data[`SPVCR_BIT_ARB_HOLD];
        end
        default: begin
          // Other offsets carry no loadable field
        end
      endcase
    end
    rpl_eff_d = rpl_en_d ? rpl_val_d : `SPVCR_REPLAY_DEF;
    ack_eff_d = ack_en_d ? ack_val_d : `SPVCR_ACK_DEF;
    // Read mux, unmapped offsets return zero
    rd_ack_d = cfg_rd;
    rdata_d  = 32'h00000000;
    if (cfg_rd) begin
      case (rsel)
        SPVCR_SEL_MSG_DATA: rdata_d = {16'h0000, msg_q};
        SPVCR_SEL_CAP_HDR:  rdata_d = cap_word;
        SPVCR_SEL_SCRATCH0: rdata_d = scr0_q;
        SPVCR_SEL_SCRATCH1: rdata_d = scr1_q;
        SPVCR_SEL_TIMER:    rdata_d = timer_word;
        SPVCR_SEL_FWD_MODE: rdata_d = mode_word;
        default:            rdata_d = 32'h00000000;
      endcase
    end
  end

  // Register all state and outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      msg_q     <= `SPVCR_MSG_DATA_RST;
      scr0_q    <= `SPVCR_SCRATCH0_RST;
      scr1_q    <= `SPVCR_SCRATCH1_RST;
      rpl_val_q <= `SPVCR_REPLAY_VAL_RST;
      rpl_en_q  <= 1'b0;
      ack_val_q <= `SPVCR_ACK_VAL_RST;
      ack_en_q  <= 1'b0;
      pm_dis_q  <= 1'b0;
      msi_dis_q <= 1'b0;
      sf_q      <= 1'b0;
      ct_q      <= `SPVCR_CT_THR_RST;
      arb_q     <= 1'b0;
      cfg_rdata_q       <= 32'h00000000;
      cfg_rd_ack_q      <= 1'b0;
      msg_data_q        <= `SPVCR_MSG_DATA_RST;
      replay_timeout_q  <= `SPVCR_REPLAY_DEF;
      ack_latency_q     <= `SPVCR_ACK_DEF;
      pm_cap_dis_q      <= 1'b0;
      msi_cap_dis_q     <= 1'b0;
      vga_decode_en_q   <= 1'b1;
      store_forward_q   <= 1'b0;
      ct_early_cycles_q <= `SPVCR_CT_THR_RST;
      arb_hold_grant_q  <= 1'b0;
      scratch0_q        <= `SPVCR_SCRATCH0_RST;
      scratch1_q        <= `SPVCR_SCRATCH1_RST;
    end else begin
      msg_q     <= msg_d;
      scr0_q    <= scr0_d;
      scr1_q    <= scr1_d;
      rpl_val_q <= rpl_val_d;
      rpl_en_q  <= rpl_en_d;
      ack_val_q <= ack_val_d;
      ack_en_q  <= ack_en_d;
      pm_dis_q  <= pm_dis_d;
      msi_dis_q <= msi_dis_d;
      sf_q      <= sf_d;
      ct_q      <= ct_d;
      arb_q     <= arb_d;
      cfg_rdata_q       <= rdata_d;
      cfg_rd_ack_q      <= rd_ack_d;
      msg_data_q        <= msg_d;
      replay_timeout_q  <= rpl_eff_d;
      ack_latency_q     <= ack_eff_d;
      pm_cap_dis_q      <= pm_dis_d;
      msi_cap_dis_q     <= msi_dis_d;
      vga_decode_en_q   <= 1'b1;
      store_forward_q   <= sf_d;
      ct_early_cycles_q <= ct_d;
      arb_hold_grant_q  <= arb_d;
      scratch0_q        <= scr0_d;
      scratch1_q        <= scr1_d;
    end
  end

  // Checks on the register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd(logic [7:0] ofs);
    cfg_rd && cfg_addr == ofs;
  endsequence

  chk_msg_upper_zero: assert property (
    s_rd(`SPVCR_OFS_MSG_DATA) |=> cfg_rd_ack_q && cfg_rdata_q[31:16] == 16'h0000)
    else $error("message data upper half not zero");
  chk_cap_id_byte: assert property (
    s_rd(`SPVCR_OFS_CAP_HDR) |=> cfg_rdata_q[7:0] == 8'h09)
    else $error("capability id wrong");
  chk_cap_next_ptr: assert property (
    s_rd(`SPVCR_OFS_CAP_HDR) |=> cfg_rdata_q[15:8] == 8'hB0)
    else $error("next pointer wrong");
  chk_cap_length: assert property (
    s_rd(`SPVCR_OFS_CAP_HDR) |=> cfg_rdata_q[31:16] == 16'h0034)
    else $error("capability length wrong");
  chk_replay_select: assert property (
    (cfg_wr && !load_wr && cfg_addr == `SPVCR_OFS_TIMER_CTL && cfg_be == 4'hF)
    |=> replay_timeout_q == ($past(cfg_wdata[12]) ? $past(cfg_wdata[11:0])
                                                  : `SPVCR_REPLAY_DEF))
    else $error("replay timeout selection wrong");
  chk_ack_select: assert property (
    (cfg_wr && !load_wr && cfg_addr == `SPVCR_OFS_TIMER_CTL && cfg_be == 4'hF)
    |=> ack_latency_q == ($past(cfg_wdata[30]) ? $past(cfg_wdata[29:16])
                                               : `SPVCR_ACK_DEF))
    else $error("ack latency selection wrong");
  chk_vga_read_one: assert property (
    s_rd(`SPVCR_OFS_TIMER_CTL) |=> cfg_rdata_q[31] && vga_decode_en_q)
    else $error("vga decode bit not one");
  chk_load_mode: assert property (
    (load_wr && load_addr == `SPVCR_OFS_FWD_MODE) |=>
      store_forward_q == $past(load_data[0]) &&
      ct_early_cycles_q == $past(load_data[2:1]) &&
      arb_hold_grant_q == $past(load_data[3]))
    else $error("loaded mode not applied");
  chk_mode_readback: assert property (
    (cfg_wr && !load_wr && cfg_addr == `SPVCR_OFS_FWD_MODE && cfg_be[0])
    ##1 s_rd(`SPVCR_OFS_FWD_MODE) |=> cfg_rdata_q[3:0] == $past(cfg_wdata[3:0], 2))
    else $error("mode readback mismatch");
  chk_scratch_write: assert property (
    (cfg_wr && cfg_addr == `SPVCR_OFS_SCRATCH0 && cfg_be == 4'hF)
    |=> scratch0_q == $past(cfg_wdata))
    else $error("scratch write lost");
  chk_reset_values: assert property (@(posedge clk)
    $past(reset) |-> ct_early_cycles_q == 2'h1 && scratch1_q == 32'h00000800)
    else $error("reset value wrong");

endmodule

//--- tb/tb_spvcr_regbank.sv
// Self-checking bench for the switch port configuration register bank
`timescale 1ns/100ps
`include "spvcr_regs.svh"

module tb_spvcr_regbank
  import spvcr_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [3:0]  be;
    logic [31:0] wd;
    logic [31:0] rb;
  } spvcr_row_s;

  logic        clk, reset, cfg_wr, cfg_rd, load_wr;
  logic [7:0]  cfg_addr, load_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, load_data, cfg_rdata_q, scratch0_q, scratch1_q;
  logic        cfg_rd_ack_q, pm_cap_dis_q, msi_cap_dis_q, vga_decode_en_q;
  logic        store_forward_q, arb_hold_grant_q;
  logic [15:0] msg_data_q;
  logic [11:0] replay_timeout_q;
  logic [13:0] ack_latency_q;
  logic [1:0]  ct_early_cycles_q;
  int          fails, num_checks, cycles;
  spvcr_row_s  rows [7];

  spvcr_regbank uut (
    .clk(clk), .reset(reset), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rd_ack_q(cfg_rd_ack_q), .load_wr(load_wr), .load_addr(load_addr),
    .load_data(load_data), .msg_data_q(msg_data_q), .replay_timeout_q(replay_timeout_q),
    .ack_latency_q(ack_latency_q), .pm_cap_dis_q(pm_cap_dis_q),
    .msi_cap_dis_q(msi_cap_dis_q), .vga_decode_en_q(vga_decode_en_q),
    .store_forward_q(store_forward_q), .ct_early_cycles_q(ct_early_cycles_q),
    .arb_hold_grant_q(arb_hold_grant_q), .scratch0_q(scratch0_q), .scratch1_q(scratch1_q)
  );

  // Clock of 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Read one word, answer stands the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge clk);
    cfg_rd = 1'b0;
    check(32'(cfg_rd_ack_q), 32'h1, "ack");
    check(cfg_rdata_q, exp, "rdata");
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask

  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    load_wr = 1'b1;
    load_addr = a;
    load_data = d;
    @(negedge clk);
    load_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic do_reset;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
  endtask

  // Reset values at the outputs and readback
  task automatic chk_defaults;
    check(32'(msg_data_q), 32'h0, "msg");
    check(32'(replay_timeout_q), 32'(`SPVCR_REPLAY_DEF), "rpl");
    check(32'(ack_latency_q), 32'(`SPVCR_ACK_DEF), "ackl");
    check(32'({pm_cap_dis_q, msi_cap_dis_q}), 32'h0, "dis");
    check(32'(vga_decode_en_q), 32'h1, "vga");
    check(32'(store_forward_q), 32'h0, "sf");
    check(32'(ct_early_cycles_q), 32'h1, "ct");
    check(32'(arb_hold_grant_q), 32'h0, "arb");
    check(scratch0_q, 32'h04001060, "s0");
    check(scratch1_q, 32'h00000800, "s1");
    check(32'(cfg_rd_ack_q), 32'h0, "ack0");
    rd_chk(8'h70, 32'h80000000);
    rd_chk(8'h74, 32'h00000002);
  endtask

  initial begin
    {reset, cfg_wr, cfg_rd, load_wr, cfg_addr, load_addr, cfg_be} = '0;
    {cfg_wdata, load_data, fails, num_checks, cycles} = '0;
    rows[0] = '{8'h58, 4'hF, 32'hFFFFFFFF, 32'h0000FFFF};
    rows[1] = '{8'h64, 4'hF, 32'hFFFFFFFF, 32'h0034B009};
    rows[2] = '{8'h68, 4'hF, 32'hA5A5A5A5, 32'hA5A5A5A5};
    rows[3] = '{8'h6C, 4'h3, 32'h12345678, 32'h00005678};
    rows[4] = '{8'h70, 4'hF, 32'h7FFF1FFF, 32'hFFFF1FFF};
    rows[5] = '{8'h74, 4'hF, 32'h0000000F, 32'h0000000F};
    rows[6] = '{8'h60, 4'hF, 32'hFFFFFFFF, 32'h00000000};
    @(negedge clk);
    do_reset();
    chk_defaults();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].be, rows[i].wd);
      rd_chk(rows[i].a, rows[i].rb);
    end
    check(32'(cfg_rd_ack_q), 32'h0, "ack pulse");
    wr(8'h70, 4'hF, 32'h00450123);
    check(32'(replay_timeout_q), 32'(`SPVCR_REPLAY_DEF), "rpl off");
    check(32'(ack_latency_q), 32'(`SPVCR_ACK_DEF), "ack off");
    @(negedge clk);
    wr(8'h70, 4'hC, 32'h40450000);
    check(32'(ack_latency_q), 32'h0045, "ack on");
    @(negedge clk);
    wr(8'h70, 4'h3, 32'h00001123);
    check(32'(replay_timeout_q), 32'h123, "rpl on");
    for (int i = 0; i < 16; i++) begin
      wr(8'h74, 4'h1, 32'(i));
      check(32'(store_forward_q), 32'(i & 1), "sf");
      check(32'(ct_early_cycles_q), 32'((i >> 1) & 3), "ct");
      check(32'(arb_hold_grant_q), 32'((i >> 3) & 1), "arb");
      @(negedge clk);
    end
    // default replacement through the load port
    ld(8'h70, 32'h00006000);
    check(32'({pm_cap_dis_q, msi_cap_dis_q}), 32'h3, "dis load");
    ld(8'h68, 32'h0);
    check(scratch0_q, 32'hA5A5A5A5, "load ignored");
    // Load and software write hit the mode word on one edge
    load_wr = 1'b1;
    load_addr = 8'h74;
    load_data = 32'h1;
    cfg_wr = 1'b1;
    cfg_addr = 8'h74;
    cfg_be = 4'hF;
    cfg_wdata = 32'h8;
    @(negedge clk);
    load_wr = 1'b0;
    cfg_wr = 1'b0;
    check(32'({store_forward_q, arb_hold_grant_q}), 32'h2, "load wins");
    @(negedge clk);
    // read in the same cycle as a write sees the old word
    cfg_rd = 1'b1;
    cfg_wr = 1'b1;
    cfg_addr = 8'h68;
    cfg_wdata = 32'h0000BEEF;
    @(negedge clk);
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    check(cfg_rdata_q, 32'hA5A5A5A5, "old word");
    @(negedge clk);
    rd_chk(8'h68, 32'h0000BEEF);
    // Second reset in mid-run
    do_reset();
    chk_defaults();
    give_verdict();
  end
endmodule
